// >>> csw_cfg.svh
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define CSW_OFF_UPPER 3'h0
`define CSW_OFF_LOWER 3'h1
`define CSW_OFF_PBASE 3'h2
`define CSW_OFF_MBASE 3'h3
`define CSW_OFF_MPSIZE 3'h4
`define CSW_OFF_AUX 3'h5
`define CSW_OFF_STATUS 3'h6
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSW_RDY_BIT 2
`define CSW_W3_BIT 3
`define CSW_DA_BIT 7
`define CSW_MP_EXT_BIT 7
`define CSW_MP_IO_BIT 6
`define CSW_MP_ALL_BIT 5
`define CSW_MP_LATCH_BIT 4
`define CSW_AUX_LOWER_BIT 0
`define CSW_AUX_OTHER_BIT 1
`define CSW_AUX_IO_BIT 2
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSW_UPPER_RST 16'hF03F
`define CSW_LOWER_RST 16'h0000
`define CSW_PBASE_RST 16'h0000
`define CSW_MBASE_RST 16'h0000
`define CSW_MPSIZE_RST 16'h0000
`define CSW_AUX_RST 16'h0000
`define CSW_UPPER_MIN 4'hF
`define CSW_UPPER_LOW 4'h8
`endif

// >>> csw_mem_model.sv
`timescale 1ns/1ps
module csw_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Selects seen and answer delay
  input wire logic [11:0] sel_n,
  input wire logic [3:0] delay,
  // Ready back to the unit
  output logic ready
);
  logic [3:0] cnt;
  // Ready rises a set time after any select, drops with the selects
  always_ff @(posedge mclk) begin
    if (!rst_n || &sel_n) begin
      cnt <= 4'h0;
      ready <= 1'b0;
    end else begin
      if (cnt != delay) cnt <= cnt + 4'h1;
      ready <= (cnt == delay);
    end
  end
endmodule // csw_mem_model

// >>> csw_pkg.sv
package csw_pkg;
  typedef enum logic [1:0] {
    CSW_IDLE = 2'b00,
    CSW_WAIT = 2'b01,
    CSW_RDY = 2'b11,
    CSW_DONE = 2'b10
  } csw_state_type;
  typedef logic [19:0] csw_addr_type;
  typedef logic [15:0] csw_word_type;
  typedef struct packed {
    logic ext_ready;
    logic [3:0] waits;
  } csw_wait_type;
endpackage

// >>> csw_unit.sv
`timescale 1ns/1ps
`include "csw_cfg.svh"
// Notes on behaviour
// - Address-suppress bit blocks address drive
// - Select waits apply even as general I/O
// - Hidden fifth peripheral select keeps wait logic
// - Latched-address mode disables top-two wait logic
// - Reset: upper select active, 64K, ready, 3 waits
// - Upper range programmable 64K to 512K
// - Lower select inactive until programmed
// - Aux setting picks 8/16-bit width
// - Midrange base anywhere in 1M space
// - First midrange select may cover whole block
// - Midrange width follows other-memory width
// - Midrange/peripheral selects use multiplexed timing
// - Peripheral selects decode consecutive 256-byte blocks
// - Peripheral selects inactive after reset
// - Top two 0-3 waits, lower four more
// - Peripheral width follows memory or I/O width
// - Upper/lower selects use non-multiplexed timing
// - Ready enable bit and 2-bit wait field
// - Programmed waits complete before external ready
// - Selects assert for CPU and DMA cycles
module csw_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire csw_pkg::csw_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output csw_pkg::csw_word_type reg_rdata,
  // Bus cycle from CPU or DMA
  input wire logic cyc_start,
  input wire logic cyc_addr_phase,
  input wire logic cyc_io,
  input wire logic cyc_dma,
  input wire csw_pkg::csw_addr_type cyc_addr,
  // External ready pin
  input wire logic ext_ready_pin,
  // Select outputs, active low, and latched address bits
  output logic upper_select_n,
  output logic lower_select_n,
  output logic [3:0] midrange_memory_selects_n,
  output logic [3:0] lower_four_peripheral_selects_n,
  output logic sixth_peripheral_select_n,
  output logic seventh_peripheral_select_n,
  output logic latched_addr_bit1,
  output logic latched_addr_bit2,
  // Bus control
  output logic suppress_address_drive,
  output logic bus_width16,
  output logic cycle_done,
  output logic cycle_busy
);
  import csw_pkg::*;
  csw_word_type upper_region_control;
  csw_word_type lower_region_control;
  csw_word_type peripheral_base_control;
  csw_word_type midrange_base_control;
  csw_word_type midrange_peripheral_size_control;
  csw_word_type auxiliary_width_config;
  logic lower_en, pcs_en, mcs_en;
  logic rdy_meta, rdy_sync;
  csw_addr_type addr_q;
  logic io_q;
  logic dma_q;
  logic hit_u, hit_l, hit_p_any;
  logic [3:0] hit_m;
  logic [6:0] hit_p;
  csw_wait_type next_cfg;
  logic cyc_start_q;
  csw_wait_if wif ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic csw_wait_type wait_of(input csw_word_type r,
                                           input logic wide);
    csw_wait_type w;
    logic [3:0] n;
    w.ext_ready = r[`CSW_RDY_BIT];
    n = {2'b00, r[1:0]};
    if (wide && r[`CSW_W3_BIT]) begin
      case (r[1:0])
        2'b00: n = 4'h5;
        2'b01: n = 4'h7;
        2'b10: n = 4'h9;
        default: n = 4'hF;
      endcase
    end
    w.waits = n;
    return w;
  endfunction

  function automatic csw_wait_type merge(input csw_wait_type a,
                                         input csw_wait_type b);
    csw_wait_type w;
    w.ext_ready = a.ext_ready | b.ext_ready;
    w.waits = (a.waits > b.waits) ? a.waits : b.waits;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upper_region_control <= `CSW_UPPER_RST;
      lower_region_control <= `CSW_LOWER_RST;
      peripheral_base_control <= `CSW_PBASE_RST;
      midrange_base_control <= `CSW_MBASE_RST;
      midrange_peripheral_size_control <= `CSW_MPSIZE_RST;
      auxiliary_width_config <= `CSW_AUX_RST;
      lower_en <= 1'b0;
      pcs_en <= 1'b0;
      mcs_en <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CSW_OFF_UPPER: upper_region_control <= reg_wdata;
        `CSW_OFF_LOWER: begin
          lower_region_control <= reg_wdata;
          lower_en <= 1'b1;
        end
        `CSW_OFF_PBASE: begin
          peripheral_base_control <= reg_wdata;
          pcs_en <= 1'b1;
        end
        `CSW_OFF_MBASE: begin
          midrange_base_control <= reg_wdata;
          mcs_en <= 1'b1;
        end
        `CSW_OFF_MPSIZE: midrange_peripheral_size_control <= reg_wdata;
        `CSW_OFF_AUX: auxiliary_width_config <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSW_OFF_UPPER: reg_rdata <= upper_region_control;
        `CSW_OFF_LOWER: reg_rdata <= lower_region_control;
        `CSW_OFF_PBASE: reg_rdata <= peripheral_base_control;
        `CSW_OFF_MBASE: reg_rdata <= midrange_base_control;
        `CSW_OFF_MPSIZE: reg_rdata <= midrange_peripheral_size_control;
        `CSW_OFF_AUX: reg_rdata <= auxiliary_width_config;
        `CSW_OFF_STATUS: reg_rdata <= {9'h000, wif.busy, lower_en,
                                       mcs_en, pcs_en, dma_q, io_q,
                                       hit_p_any};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Ready pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rdy_meta <= ext_ready_pin;
      rdy_sync <= rdy_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle capture
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_q <= 20'h00000;
      io_q <= 1'b0;
      dma_q <= 1'b0;
    end else if (cyc_start) begin
      addr_q <= cyc_addr;
      io_q <= cyc_io;
      dma_q <= cyc_dma;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] ublk;
    logic [19:0] mbase, pbase, msize, moff;
    logic [15:0] poff;
    ublk = {1'b0, upper_region_control[15:12]};
    if (ublk[3:0] < `CSW_UPPER_LOW) begin
      ublk = {1'b0, `CSW_UPPER_LOW};
    end
    hit_u = !io_q && ({1'b0, addr_q[19:16]} >= ublk);
    hit_l = lower_en && !io_q &&
            (addr_q[19:10] <= lower_region_control[15:6]);
    mbase = {midrange_base_control[15:9], 13'h0000};
    msize = {midrange_peripheral_size_control[14:8], 13'h0000};
    moff = addr_q - mbase;
    hit_m = 4'h0;
    if (mcs_en && !io_q && addr_q >= mbase && moff < msize) begin
      // Each select covers one quarter of the block; with the all bit set the first select covers the whole block
      if (midrange_peripheral_size_control[`CSW_MP_ALL_BIT]) begin
        hit_m = 4'h1;
      end else if (moff < (msize >> 2)) begin
        hit_m = 4'h1;
      end else if (moff < (msize >> 1)) begin
        hit_m = 4'h2;
      end else if (moff < (msize >> 1) + (msize >> 2)) begin
        hit_m = 4'h4;
      end else begin
        hit_m = 4'h8;
      end
    end
    pbase = {peripheral_base_control[15:6], 10'h000};
    poff = addr_q[15:0] - pbase[15:0];
    hit_p = 7'h00;
    if (pcs_en &&
        (midrange_peripheral_size_control[`CSW_MP_IO_BIT] == io_q) &&
        (io_q || addr_q[19:16] == pbase[19:16]) &&
        addr_q[15:0] >= pbase[15:0] && poff[15:11] == 5'h00) begin
      hit_p = 7'h01 << poff[10:8];
    end
    hit_p_any = |hit_p;
  end

  // ----------------------------------------------------------------------
  // Wait settings, combined over all matches except the top two selects in latched-address mode
  // ----------------------------------------------------------------------
  always_comb begin
    logic latch_mode;
    latch_mode = midrange_peripheral_size_control[`CSW_MP_LATCH_BIT];
    next_cfg = '0;
    if (hit_u) next_cfg = merge(next_cfg, wait_of(upper_region_control,
                                                  1'b0));
    if (hit_l) next_cfg = merge(next_cfg, wait_of(lower_region_control,
                                                  1'b0));
    if (|hit_m) next_cfg = merge(next_cfg, wait_of(midrange_base_control,
                                                   1'b0));
    if (|hit_p[4:0]) next_cfg = merge(next_cfg,
      wait_of(peripheral_base_control, !hit_p[4]));
    if (|hit_p[6:5] && !latch_mode) next_cfg = merge(next_cfg,
      wait_of(midrange_peripheral_size_control, 1'b0));
  end

  assign wif.start = cyc_start_q;
  assign wif.cfg = next_cfg;
  assign wif.ready_sync = rdy_sync;

  always_ff @(posedge mclk) begin
    if (!rst_n) cyc_start_q <= 1'b0;
    else cyc_start_q <= cyc_start && !wif.busy;
  end

  csw_wait_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .wif(wif)
  );

  // ----------------------------------------------------------------------
  // Select outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upper_select_n <= 1'b1;
      lower_select_n <= 1'b1;
      midrange_memory_selects_n <= 4'hF;
      lower_four_peripheral_selects_n <= 4'hF;
      sixth_peripheral_select_n <= 1'b1;
      seventh_peripheral_select_n <= 1'b1;
      suppress_address_drive <= 1'b0;
    end else if (wif.busy || cyc_start_q) begin
      upper_select_n <= !hit_u;
      lower_select_n <= !hit_l;
      midrange_memory_selects_n <= cyc_addr_phase ? 4'hF : ~hit_m;
      lower_four_peripheral_selects_n <= cyc_addr_phase ? 4'hF :
                                         ~hit_p[3:0];
      sixth_peripheral_select_n <= cyc_addr_phase || !hit_p[5];
      seventh_peripheral_select_n <= cyc_addr_phase || !hit_p[6];
      suppress_address_drive <=
        (hit_u && upper_region_control[`CSW_DA_BIT]) ||
        (hit_l && lower_region_control[`CSW_DA_BIT]);
    end else begin
      upper_select_n <= 1'b1;
      lower_select_n <= 1'b1;
      midrange_memory_selects_n <= 4'hF;
      lower_four_peripheral_selects_n <= 4'hF;
      sixth_peripheral_select_n <= 1'b1;
      seventh_peripheral_select_n <= 1'b1;
      suppress_address_drive <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Width, latched address and cycle status
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_width16 <= 1'b1;
      latched_addr_bit1 <= 1'b0;
      latched_addr_bit2 <= 1'b0;
      cycle_done <= 1'b0;
      cycle_busy <= 1'b0;
    end else begin
      if (hit_l) begin
        bus_width16 <= !auxiliary_width_config[`CSW_AUX_LOWER_BIT];
      end else if (hit_p_any && io_q) begin
        bus_width16 <= !auxiliary_width_config[`CSW_AUX_IO_BIT];
      end else if (!hit_u) begin
        bus_width16 <= !auxiliary_width_config[`CSW_AUX_OTHER_BIT];
      end else begin
        bus_width16 <= 1'b1;
      end
      latched_addr_bit1 <= midrange_peripheral_size_control
                           [`CSW_MP_LATCH_BIT] & addr_q[1];
      latched_addr_bit2 <= midrange_peripheral_size_control
                           [`CSW_MP_LATCH_BIT] & addr_q[2];
      cycle_done <= wif.done;
      cycle_busy <= wif.busy;
    end
  end
endmodule // csw_unit

// >>> csw_unit_asserts.sv
`timescale 1ns/1ps
module csw_unit_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire logic reg_rd,
  input wire logic cyc_start,
  input wire logic cyc_addr_phase,
  input wire csw_pkg::csw_word_type reg_rdata,
  input wire logic upper_select_n,
  input wire logic lower_select_n,
  input wire logic [3:0] midrange_memory_selects_n,
  input wire logic [3:0] lower_four_peripheral_selects_n,
  input wire logic sixth_peripheral_select_n,
  input wire logic seventh_peripheral_select_n,
  input wire logic suppress_address_drive,
  input wire logic cycle_done,
  input wire logic cycle_busy
);
  import csw_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic far_n;
  assign far_n = &{midrange_memory_selects_n,
    lower_four_peripheral_selects_n, sixth_peripheral_select_n,
    seventh_peripheral_select_n};
  sequence s_idle3; (!cycle_busy && !cyc_start) [*3]; endsequence
  sequence s_addr2; cyc_addr_phase [*2]; endsequence
  sequence s_take; cyc_start && !cycle_busy; endsequence
  property p_reset_off; $rose(rst_n) |-> far_n && lower_select_n;
  endproperty
  property p_addr; s_addr2 |-> far_n; endproperty
  property p_idle; s_idle3 |-> far_n && upper_select_n && lower_select_n;
  endproperty
  property p_done; cycle_done |=> !cycle_done; endproperty
  property p_start; s_take |-> ##[1:3] cycle_busy; endproperty
  property p_end; cycle_done |-> ##[0:2] !cycle_busy; endproperty
  property p_minwait; $rose(cycle_busy) |-> !cycle_done [*2]; endproperty
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  property p_suppress;
    suppress_address_drive |-> !(upper_select_n && lower_select_n);
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("select active right after reset");
  a_addr: assert property (p_addr)
    else $error("select active in address phase");
  a_idle: assert property (p_idle)
    else $error("select active while idle");
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  a_start: assert property (p_start)
    else $error("bus cycle not taken");
  a_end: assert property (p_end)
    else $error("busy stays after done");
  a_minwait: assert property (p_minwait)
    else $error("cycle ended too early");
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");
  a_suppress: assert property (p_suppress)
    else $error("address suppressed without select");
endmodule // csw_unit_asserts
bind csw_unit csw_unit_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
  .reg_rd(reg_rd), .cyc_start(cyc_start), .cyc_addr_phase(cyc_addr_phase),
  .reg_rdata(reg_rdata), .upper_select_n(upper_select_n),
  .lower_select_n(lower_select_n),
  .midrange_memory_selects_n(midrange_memory_selects_n),
  .lower_four_peripheral_selects_n(lower_four_peripheral_selects_n),
  .sixth_peripheral_select_n(sixth_peripheral_select_n),
  .seventh_peripheral_select_n(seventh_peripheral_select_n),
  .suppress_address_drive(suppress_address_drive),
  .cycle_done(cycle_done), .cycle_busy(cycle_busy));

// >>> csw_wait_if.sv
`timescale 1ns/1ps
interface csw_wait_if;
  import csw_pkg::*;
  logic start;
  csw_wait_type cfg;
  logic ready_sync;
  logic done;
  logic busy;
  modport ctrl (output start, output cfg, output ready_sync,
    input done, input busy);
  modport timer (input start, input cfg, input ready_sync,
    output done, output busy);
endinterface

// >>> csw_wait_timer.sv
`timescale 1ns/1ps
module csw_wait_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control side
  csw_wait_if.timer wif
);
  import csw_pkg::*;
  csw_state_type state;
  logic [3:0] count;
  logic use_rdy;
  logic done_q;
  assign wif.done = done_q;
  assign wif.busy = (state != CSW_IDLE);
  // ----------------------------------------------------------------------
  // Wait counting: programmed waits finish before ready is honoured
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= CSW_IDLE;
      count <= 4'h0;
      use_rdy <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state)
        CSW_IDLE: begin
          if (wif.start) begin
            count <= wif.cfg.waits;
            use_rdy <= wif.cfg.ext_ready;
            state <= CSW_WAIT;
          end
        end
        CSW_WAIT: begin
          if (count != 4'h0) begin
            count <= count - 4'h1;
          end else begin
            state <= use_rdy ? CSW_RDY : CSW_DONE;
          end
        end
        CSW_RDY: begin
          if (wif.ready_sync) begin
            state <= CSW_DONE;
          end
        end
        CSW_DONE: begin
          done_q <= 1'b1;
          state <= CSW_IDLE;
        end
        default: state <= CSW_IDLE;
      endcase
    end
  end
endmodule // csw_wait_timer

// >>> test_chip_select_waitstate_unit.sv
`timescale 1ns/1ps
`include "csw_cfg.svh"
module test_chip_select_waitstate_unit;
  import csw_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd, cyc_start, cyc_addr_phase;
  logic cyc_io, cyc_dma, rdy, up_n, lo_n, s6_n, s7_n;
  logic lab1, lab2, sad, w16, cycle_done, cycle_busy;
  logic [2:0] reg_addr;
  logic [3:0] mid_n, per_n, dly, bits;
  csw_word_type reg_wdata, reg_rdata, rv;
  csw_addr_type cyc_addr;
  logic [11:0] sel, snap;
  int fails, check_count, n, m, k;
  logic [11:0] ptab [7] = '{12'hFFB, 12'hFF7, 12'hFEF, 12'hFDF, 12'hFFF,
    12'hFFD, 12'hFFE};
  assign sel = {up_n, lo_n, mid_n, per_n, s6_n, s7_n};
  csw_unit dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cyc_start(cyc_start),
    .cyc_addr_phase(cyc_addr_phase), .cyc_io(cyc_io), .cyc_dma(cyc_dma),
    .cyc_addr(cyc_addr), .ext_ready_pin(rdy), .upper_select_n(up_n),
    .lower_select_n(lo_n), .midrange_memory_selects_n(mid_n),
    .lower_four_peripheral_selects_n(per_n),
    .sixth_peripheral_select_n(s6_n), .seventh_peripheral_select_n(s7_n),
    .latched_addr_bit1(lab1), .latched_addr_bit2(lab2),
    .suppress_address_drive(sad), .bus_width16(w16),
    .cycle_done(cycle_done), .cycle_busy(cycle_busy));
  csw_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .sel_n(sel),
    .delay(dly), .ready(rdy));
  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [19:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input csw_word_type d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output csw_word_type d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask
  // One bus cycle; kd is {dma, io}; address phase spans three edges
  task automatic cyc(input csw_addr_type a, input logic [1:0] kd);
    cyc_addr <= a;
    {cyc_dma, cyc_io} <= kd;
    cyc_start <= 1'b1;
    cyc_addr_phase <= 1'b1;
    @(posedge mclk);
    cyc_start <= 1'b0;
    repeat (2) @(posedge mclk);
    cyc_addr_phase <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    snap = sel;
    bits = {lab2, lab1, sad, w16};
    check("busy", cycle_busy, 1'b1);
    n = 4;
    while (cycle_done !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check("cycle end", n < 200, 1);
    repeat (4) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(25 * 20000);
    fails++;
    report_and_stop();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, cyc_start, cyc_addr_phase, cyc_io} = '0;
    {cyc_dma, reg_addr, reg_wdata, cyc_addr} = '0;
    dly = 4'h1;
    fails = 0;
    check_count = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`CSW_OFF_UPPER, rv); check("upper ctl", rv, 16'hF03F);
    rd(`CSW_OFF_LOWER, rv); check("lower ctl", rv, 16'h0000);
    rd(3'h7, rv); check("unmapped", rv, 16'h0000);
    cyc(20'hFFFF0, 2'b00); check("reset upper", snap, 12'h7FF);
    m = n;
    dly <= 4'h9;
    cyc(20'hFFFF0, 2'b00); check("late ready", n > m, 1);
    check("three waits", m >= 7, 1);
    cyc(20'h00000, 2'b00); check("zero idle", snap, 12'hFFF);
    // Overlapping ranges never get differing wait settings
    wr(`CSW_OFF_UPPER, 16'h8038);
    cyc(20'h80000, 2'b00); check("upper 512K", snap, 12'h7FF);
    m = n;
    dly <= 4'h1;
    cyc(20'h80000, 2'b00); check("ready off", n, m);
    wr(`CSW_OFF_LOWER, 16'h00C0);
    cyc(20'h00100, 2'b00); check("lower hit", snap, 12'hBFF);
    check("suppress", bits[1], 1'b1);
    wr(`CSW_OFF_AUX, 16'h0001);
    cyc(20'h00100, 2'b00); check("lower width", bits[0], 1'b0);
    wr(`CSW_OFF_PBASE, 16'h0800);
    wr(`CSW_OFF_MPSIZE, 16'h0100);
    for (k = 0; k < 7; k++) begin
      cyc(20'h08000 + 20'(k * 256), 2'b00);
      check("periph decode", snap, ptab[k]);
    end
    m = n;
    wr(`CSW_OFF_PBASE, 16'h080B);
    cyc(20'h08000, 2'b00); check("15 waits", n - m, 15);
    wr(`CSW_OFF_MPSIZE, 16'h0113);
    cyc(20'h08506, 2'b00); check("latched", bits[3:2], 2'b11);
    check("sixth kept", snap, 12'hFFD);
    check("latch waits", n, m);
    wr(`CSW_OFF_MPSIZE, 16'h0140);
    wr(`CSW_OFF_AUX, 16'h0004);
    cyc(20'h08100, 2'b11); check("io periph", snap, 12'hFF7);
    check("io width", bits[0], 1'b0);
    rd(`CSW_OFF_STATUS, rv); check("status", rv, 16'h002F);
    wr(`CSW_OFF_AUX, 16'h0002);
    wr(`CSW_OFF_MBASE, 16'h2000);
    cyc(20'h20000, 2'b10); check("mid base", snap, 12'hFBF);
    check("mid width", bits[0], 1'b0);
    cyc(20'h21F00, 2'b00); check("mid quarter", snap, 12'hDFF);
    wr(`CSW_OFF_MPSIZE, 16'h0160);
    cyc(20'h21F00, 2'b00); check("mid whole", snap, 12'hFBF);
    report_and_stop();
  end
endmodule // test_chip_select_waitstate_unit
